// [bench/dg_properties.sv]
/* Port checker for the datagram address decoder.
   Assumes a bind from the bench and one byte per valid beat. */
`timescale 1ns/10ps
module dg_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Stream
    input wire logic in_valid,
    input wire logic in_sof,
    input wire logic [7:0] in_data,
    input wire logic out_valid,
    input wire logic out_sof,
    input wire logic [7:0] out_data,
    // Addressing
    input wire logic [15:0] station_addr,
    input wire logic alias_enable,
    input wire logic eeprom_load_done,
    input wire logic [15:0] eeprom_alias,
    input wire logic [31:0] map_start,
    input wire logic [31:0] map_end,
    input wire logic map_enable,
    input wire logic [15:0] active_alias,
    input wire logic addressed
);
    // ----------------------------------------
    // Beat tracking
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [11:0] cnt_q;
    logic [7:0] cmd_q;
    logic [7:0] lo_q;
    logic [31:0] adr_q;
    logic seen_q;
    logic pos_c, all_c, node_c, log_c, pass_c;
    // Saturates so idle gaps never alias a header beat
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_q <= 12'hFFF;
        else if (in_valid && in_sof)
            cnt_q <= 12'h001;
        else if (in_valid && cnt_q != 12'hFFF)
            cnt_q <= cnt_q + 12'h001;
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cmd_q <= 8'h00;
        else if (in_valid && in_sof)
            cmd_q <= in_data;
    end
    always_ff @(posedge clk)
    begin
        if (in_valid && cnt_q == 12'h002)
            lo_q <= in_data;
        if (in_valid && cnt_q >= 12'h002 && cnt_q <= 12'h005)
            adr_q <= {in_data, adr_q[31:8]};
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            seen_q <= 1'b0;
        else if (eeprom_load_done)
            seen_q <= 1'b1;
    end
    assign pos_c = cmd_q inside {8'h01, 8'h02, 8'h03};
    assign node_c = cmd_q inside {8'h04, 8'h05, 8'h06};
    assign all_c = cmd_q inside {8'h07, 8'h08, 8'h09};
    assign log_c = cmd_q inside {8'h0A, 8'h0B, 8'h0C};
    assign pass_c = cmd_q inside {8'h00, 8'h02, 8'h05, 8'h08}
        || (pos_c && adr_q[15:0] != 16'h0000)
        || (node_c && adr_q[15:0] != station_addr
        && !(alias_enable && adr_q[15:0] == active_alias));
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_valid;
        out_valid == $past(in_valid, 2);
    endproperty
    a_valid: assert property (p_valid)
        else $error("out_valid not two beats behind");
    property p_sof;
        out_sof |-> $past(in_sof, 2);
    endproperty
    a_sof: assert property (p_sof)
        else $error("out_sof without sof");
    property p_index;
        in_valid && cnt_q == 12'h001 |-> ##2 out_data == $past(in_data, 2);
    endproperty
    a_index: assert property (p_index)
        else $error("index byte altered");
    property p_pos_lo;
        in_valid && cnt_q == 12'h002 && pos_c
            |-> ##2 out_data == $past(in_data, 2) + 8'h01;
    endproperty
    a_pos_lo: assert property (p_pos_lo)
        else $error("position low byte not stepped");
    property p_all_lo;
        in_valid && cnt_q == 12'h002 && all_c
            |-> ##2 out_data == $past(in_data, 2) + 8'h01;
    endproperty
    a_all_lo: assert property (p_all_lo)
        else $error("broadcast position not stepped");
    property p_pos_hi;
        in_valid && cnt_q == 12'h003 && (pos_c || all_c) |-> ##2
            out_data == $past(in_data, 2) + {7'h00, lo_q == 8'hFF};
    endproperty
    a_pos_hi: assert property (p_pos_hi)
        else $error("position carry wrong");
    property p_pos_hit;
        in_valid && cnt_q == 12'h009 && pos_c
            |-> addressed == (adr_q[15:0] == 16'h0000);
    endproperty
    a_pos_hit: assert property (p_pos_hit)
        else $error("position hit wrong");
    property p_node_hit;
        in_valid && cnt_q == 12'h009 && node_c
            |-> addressed == (adr_q[15:0] == station_addr
            || (alias_enable && adr_q[15:0] == active_alias));
    endproperty
    a_node_hit: assert property (p_node_hit)
        else $error("node hit wrong");
    property p_all_hit;
        in_valid && cnt_q == 12'h009 && all_c |-> addressed;
    endproperty
    a_all_hit: assert property (p_all_hit)
        else $error("broadcast not addressed");
    property p_log_hit;
        in_valid && cnt_q == 12'h009 && log_c |-> addressed ==
            (map_enable && adr_q >= map_start && adr_q <= map_end);
    endproperty
    a_log_hit: assert property (p_log_hit)
        else $error("logical hit wrong");
    property p_pass;
        in_valid && cnt_q >= 12'h00A && cnt_q != 12'hFFF && pass_c
            |-> ##2 out_data == $past(in_data, 2);
    endproperty
    a_pass: assert property (p_pass)
        else $error("payload altered");
    property p_alias_take;
        $rose(seen_q) |-> active_alias == $past(eeprom_alias);
    endproperty
    a_alias_take: assert property (p_alias_take)
        else $error("alias not taken");
    property p_alias_keep;
        seen_q |=> $stable(active_alias);
    endproperty
    a_alias_keep: assert property (p_alias_keep)
        else $error("alias replaced");
    c_pos: cover property (in_valid && cnt_q == 12'h009 && pos_c && addressed);
    c_node: cover property (in_valid && cnt_q == 12'h009 && node_c && addressed);
    c_log: cover property (in_valid && cnt_q == 12'h009 && log_c && addressed);
endmodule

// [bench/master_model.sv]
/* Network master model sending one datagram per frame.
   Assumes stimulus on falling edges and a two-beat return. */
`timescale 1ns/10ps
module master_model (
    // Clock
    input wire logic clk,
    // Toward the decoder
    output logic in_valid,
    output logic in_sof,
    output logic [7:0] in_data,
    // Back from the decoder
    input wire logic out_valid,
    input wire logic [7:0] out_data
);
    // ----------------------------------------
    // Frame sender
    // ----------------------------------------
    logic [7:0] rx [$];
    initial
    begin
        in_valid = 1'b0;
        in_sof = 1'b0;
        in_data = 8'h00;
    end
    always @(posedge clk)
        if (out_valid)
            rx.push_back(out_data);
    // Single datagram only: more bit left clear
    task automatic send(input logic [7:0] cmd, idx,
        input logic [15:0] pos, off, input logic [7:0] p [$]);
        logic [7:0] b [$];
        b = {cmd, idx, pos[7:0], pos[15:8]};
        b = {b, off[7:0], off[15:8], 8'(p.size()), 8'h00};
        b = {b, 8'h00, 8'h00, p, 8'h00, 8'h00};
        rx.delete();
        foreach (b[k])
        begin
            @(negedge clk);
            in_valid = 1'b1;
            in_sof = (k == 0);
            in_data = b[k];
        end
        @(negedge clk);
        in_valid = 1'b0;
        in_sof = 1'b0;
        // Released line must not keep a valid-looking byte
        in_data = ~in_data;
        repeat (4) @(negedge clk);
    endtask
endmodule

// [bench/tb.sv]
/* Self-checking bench for the datagram address decoder.
   Assumes the master model and the port checker beside it. */
`timescale 1ns/10ps
module tb;
    // ----------------------------------------
    // Harness
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic in_valid, in_sof, out_valid, out_sof, addressed, busy;
    logic [7:0] in_data, out_data;
    logic [15:0] station_addr = 16'h0000, eeprom_alias = 16'h0000;
    logic [15:0] active_alias;
    logic alias_enable = 1'b0, eeprom_load_done = 1'b0, map_enable = 1'b0;
    logic [31:0] map_start = 32'h00000000, map_end = 32'h00000000;
    logic [7:0] mem_m [1024];
    logic [7:0] idx_n = 8'h10;
    int err_count = 0;
    int checks = 0;
    always #10 clk = ~clk;
    datagram_address_decoder datagram_address_decoder_i (.clk(clk),
        .rst(rst), .in_valid(in_valid), .in_sof(in_sof), .in_data(in_data),
        .out_valid(out_valid), .out_sof(out_sof), .out_data(out_data),
        .station_addr(station_addr), .alias_enable(alias_enable),
        .eeprom_load_done(eeprom_load_done), .eeprom_alias(eeprom_alias),
        .map_start(map_start), .map_end(map_end), .map_enable(map_enable),
        .active_alias(active_alias), .addressed(addressed), .busy(busy));
    master_model master_model_i (.clk(clk), .in_valid(in_valid),
        .in_sof(in_sof), .in_data(in_data), .out_valid(out_valid),
        .out_data(out_data));
    task automatic check(input string what, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Expected stream worked out from a shadow of local memory
    task automatic run(input logic [7:0] cmd, input logic [15:0] pos, off,
        input logic [7:0] p [$], input bit hit);
        logic [7:0] e [$];
        logic [15:0] np;
        int a;
        np = pos;
        if (cmd inside {8'h01, 8'h02, 8'h03, 8'h07, 8'h08, 8'h09})
            np = pos + 16'h0001;
        idx_n++;
        e = {cmd, idx_n, np[7:0], np[15:8], off[7:0], off[15:8]};
        e = {e, 8'(p.size()), 8'h00, 8'h00, 8'h00};
        foreach (p[k])
        begin
            a = (int'(off) + k) % 1024;
            if (hit && cmd inside {8'h01, 8'h03, 8'h04, 8'h06})
                e.push_back(mem_m[a]);
            else if (cmd inside {8'h07, 8'h09})
                e.push_back(mem_m[a] | p[k]);
            else
                e.push_back(p[k]);
            if (hit && cmd inside {8'h02, 8'h03, 8'h05, 8'h06, 8'h08, 8'h09})
                mem_m[a] = p[k];
        end
        e = {e, 8'h00, 8'h00};
        master_model_i.send(cmd, idx_n, pos, off, p);
        check("length", 16'(master_model_i.rx.size()), 16'(e.size()));
        foreach (e[k])
            check($sformatf("byte %0d", k), {8'h00, master_model_i.rx[k]},
                {8'h00, e[k]});
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_position;
        run(8'h02, 16'h0000, 16'h0010, {8'hA5, 8'h3C}, 1);
        run(8'h01, 16'h0000, 16'h0010, {8'h00, 8'h00}, 1);
        run(8'h03, 16'h0000, 16'h0010, {8'h11, 8'h22}, 1);
        run(8'h01, 16'hFFFF, 16'h0010, {8'h5A, 8'h5B}, 0);
        run(8'h02, 16'hFFFE, 16'h0010, {8'hEE, 8'hEE}, 0);
        run(8'h01, 16'h0000, 16'h0010, {8'h00, 8'h00}, 1);
    endtask
    task automatic t_idle;
        run(8'h00, 16'h0000, 16'h0010, {8'h77, 8'h66}, 0);
        run(8'h01, 16'h0000, 16'h0010, {8'h00, 8'h00}, 1);
    endtask
    task automatic t_node;
        station_addr = 16'h1234;
        run(8'h05, 16'h1234, 16'h0020, {8'hC3, 8'h99}, 1);
        run(8'h04, 16'h1234, 16'h0020, {8'h00, 8'h00}, 1);
        run(8'h06, 16'h1234, 16'h0020, {8'h44, 8'h55}, 1);
        run(8'h06, 16'h1235, 16'h0020, {8'h01, 8'h02}, 0);
        run(8'h04, 16'h1234, 16'h0020, {8'h00, 8'h00}, 1);
    endtask
    task automatic t_alias;
        eeprom_alias = 16'hABCD;
        eeprom_load_done = 1'b1;
        @(negedge clk);
        eeprom_load_done = 1'b0;
        eeprom_alias = 16'h1111;
        repeat (2) @(negedge clk);
        eeprom_load_done = 1'b1;
        @(negedge clk);
        eeprom_load_done = 1'b0;
        repeat (2) @(negedge clk);
        check("active_alias", active_alias, 16'hABCD);
        alias_enable = 1'b1;
        run(8'h04, 16'hABCD, 16'h0020, {8'h00, 8'h00}, 1);
        alias_enable = 1'b0;
        run(8'h04, 16'hABCD, 16'h0020, {8'h00, 8'h00}, 0);
    endtask
    task automatic t_broadcast;
        run(8'h08, 16'h0003, 16'h0030, {8'h0F, 8'hF0}, 1);
        run(8'h07, 16'h00FF, 16'h0030, {8'h30, 8'h03}, 1);
        run(8'h09, 16'h0009, 16'h0030, {8'h81, 8'h18}, 1);
        run(8'h07, 16'h0000, 16'h0030, {8'h00, 8'h00}, 1);
    endtask
    task automatic t_logical;
        map_start = 32'h00001000;
        map_end = 32'h00001FFF;
        map_enable = 1'b1;
        master_model_i.send(8'h0A, 8'h40, 16'h1010, 16'h0000, {8'h01});
        check("length", 16'(master_model_i.rx.size()), 16'h000D);
        master_model_i.send(8'h0A, 8'h41, 16'h1010, 16'h0002, {8'h02});
        check("length", 16'(master_model_i.rx.size()), 16'h000D);
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_position;
        t_idle;
        t_node;
        t_alias;
        t_broadcast;
        t_logical;
        wrap_up;
    end
    initial
    begin
        #100000;
        err_count++;
        wrap_up;
    end
endmodule
bind datagram_address_decoder dg_checker dg_checker_i (.clk(clk),
    .rst(rst), .in_valid(in_valid), .in_sof(in_sof), .in_data(in_data),
    .out_valid(out_valid), .out_sof(out_sof), .out_data(out_data),
    .station_addr(station_addr), .alias_enable(alias_enable),
    .eeprom_load_done(eeprom_load_done), .eeprom_alias(eeprom_alias),
    .map_start(map_start), .map_end(map_end), .map_enable(map_enable),
    .active_alias(active_alias), .addressed(addressed));

// [hdl/datagram_address_decoder.sv]
/*
 * Datagram address decoder: addresses, reads, writes and swaps
 * datagram payload against local memory while the stream passes.
 * Assumes the byte stream begins at a datagram's command byte
 * with sof, carries one byte per valid beat, and that the caller
 * tolerates a fixed two-cycle pass-through latency.
 */
`timescale 1ns/10ps
module datagram_address_decoder (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Incoming datagram stream
    input wire logic in_valid,
    input wire logic in_sof,
    input wire logic [7:0] in_data,
    // Outgoing datagram stream, two cycles behind
    output logic out_valid,
    output logic out_sof,
    output logic [7:0] out_data,
    // Node address sources
    input wire logic [15:0] station_addr,
    input wire logic alias_enable,
    input wire logic eeprom_load_done,
    input wire logic [15:0] eeprom_alias,
    // Logical area hit from the mapping units
    input wire logic [31:0] map_start,
    input wire logic [31:0] map_end,
    input wire logic map_enable,
    // Status
    output logic [15:0] active_alias,
    output logic addressed,
    output logic busy
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {S_IDLE, S_HEAD, S_DATA, S_TAIL} state_t;
    state_t state_q;
    logic [3:0] hcnt_q;
    logic [10:0] left_q;
    logic [7:0] cmd_q;
    logic [31:0] adr_q;
    logic [15:0] off_q;
    logic more_q;
    logic hit_q;
    logic alias_taken_q;
    logic [15:0] alias_q;
    logic [7:0] d1_q;
    logic v1_q;
    logic s1_q;
    logic pay1_q;
    logic carry_q;
    logic [7:0] out_data_q;
    logic out_valid_q;
    logic out_sof_q;
    mem_if mb();

    // ------------------------------------------------------------
    // Command classification
    // ------------------------------------------------------------
    dg_pkg::family_t fam;
    logic do_rd;
    logic do_wr;
    logic do_or;
    logic logical;
    always_comb
    begin
        fam = dg_pkg::ADR_NONE;
        do_rd = 1'b0;
        do_wr = 1'b0;
        do_or = 1'b0;
        logical = 1'b0;
        case (cmd_q)
            dg_pkg::IDLE_CMD: fam = dg_pkg::ADR_NONE;
            dg_pkg::POSITION_READ_CMD:
            begin
                fam = dg_pkg::ADR_POS;
                do_rd = 1'b1;
            end
            dg_pkg::POSITION_WRITE_CMD:
            begin
                fam = dg_pkg::ADR_POS;
                do_wr = 1'b1;
            end
            dg_pkg::POSITION_SWAP_CMD:
            begin
                fam = dg_pkg::ADR_POS;
                do_rd = 1'b1;
                do_wr = 1'b1;
            end
            dg_pkg::NODE_READ_CMD:
            begin
                fam = dg_pkg::ADR_NODE;
                do_rd = 1'b1;
            end
            dg_pkg::NODE_WRITE_CMD:
            begin
                fam = dg_pkg::ADR_NODE;
                do_wr = 1'b1;
            end
            dg_pkg::NODE_SWAP_CMD:
            begin
                fam = dg_pkg::ADR_NODE;
                do_rd = 1'b1;
                do_wr = 1'b1;
            end
            dg_pkg::ALL_OR_READ_CMD:
            begin
                fam = dg_pkg::ADR_ALL;
                do_rd = 1'b1;
                do_or = 1'b1;
            end
            dg_pkg::ALL_WRITE_CMD:
            begin
                fam = dg_pkg::ADR_ALL;
                do_wr = 1'b1;
            end
            dg_pkg::ALL_OR_SWAP_CMD:
            begin
                fam = dg_pkg::ADR_ALL;
                do_rd = 1'b1;
                do_wr = 1'b1;
                do_or = 1'b1;
            end
            dg_pkg::LOGICAL_READ_CMD:
            begin
                logical = 1'b1;
                do_rd = 1'b1;
            end
            dg_pkg::LOGICAL_WRITE_CMD:
            begin
                logical = 1'b1;
                do_wr = 1'b1;
            end
            dg_pkg::LOGICAL_SWAP_CMD:
            begin
                logical = 1'b1;
                do_rd = 1'b1;
                do_wr = 1'b1;
            end
            default: fam = dg_pkg::ADR_NONE;
        endcase
    end

    // ------------------------------------------------------------
    // Address match, evaluated once the address is complete
    // ------------------------------------------------------------
    logic [15:0] pos_word;
    logic hit_now;
    assign pos_word = adr_q[15:0];
    always_comb
    begin
        hit_now = 1'b0;
        if (logical)
            hit_now = map_enable && adr_q >= map_start
                && adr_q <= map_end;
        else
            case (fam)
                dg_pkg::ADR_POS:
                    hit_now = pos_word == dg_pkg::POS_ZERO;
                dg_pkg::ADR_NODE:
                    hit_now = pos_word == station_addr
                        || (alias_enable && pos_word == alias_q);
                dg_pkg::ADR_ALL: hit_now = 1'b1;
                default: hit_now = 1'b0;
            endcase
    end

    // ------------------------------------------------------------
    // Alias capture, first load only
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            alias_q <= dg_pkg::ALIAS_RESET;
            alias_taken_q <= 1'b0;
        end
        else if (eeprom_load_done && !alias_taken_q)
        begin
            alias_q <= eeprom_alias;
            alias_taken_q <= 1'b1;
        end
    end
    assign active_alias = alias_q;

    // ------------------------------------------------------------
    // Header and payload walk
    // ------------------------------------------------------------
    logic in_pay;
    assign in_pay = in_valid && state_q == S_DATA;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= S_IDLE;
            hcnt_q <= 4'h0;
            left_q <= 11'h000;
            cmd_q <= dg_pkg::IDLE_CMD;
            adr_q <= 32'h0000_0000;
            more_q <= 1'b0;
            hit_q <= 1'b0;
        end
        else if (in_valid)
        begin
            case (state_q)
                S_IDLE:
                    if (in_sof)
                    begin
                        cmd_q <= in_data;
                        hcnt_q <= dg_pkg::POS_INDEX;
                        state_q <= S_HEAD;
                        hit_q <= 1'b0;
                    end
                S_HEAD:
                begin
                    hcnt_q <= hcnt_q + 4'h1;
                    case (hcnt_q)
                        dg_pkg::POS_ADR0: adr_q[7:0] <= in_data;
                        dg_pkg::POS_ADR1: adr_q[15:8] <= in_data;
                        dg_pkg::POS_ADR2: adr_q[23:16] <= in_data;
                        dg_pkg::POS_ADR3: adr_q[31:24] <= in_data;
                        dg_pkg::POS_LEN0:
                        begin
                            left_q[7:0] <= in_data;
                            hit_q <= hit_now;
                        end
                        dg_pkg::POS_LEN1:
                        begin
                            left_q[10:8] <= in_data[2:0];
                            more_q <= in_data[dg_pkg::MORE_BIT];
                        end
                        default: left_q <= left_q;
                    endcase
                    if (hcnt_q == dg_pkg::POS_IRQ1)
                    begin
                        hcnt_q <= 4'h0;
                        state_q <= (left_q == 11'h000) ? S_TAIL : S_DATA;
                    end
                end
                S_DATA:
                begin
                    left_q <= left_q - 11'h001;
                    if (left_q == 11'h001)
                    begin
                        hcnt_q <= 4'h0;
                        state_q <= S_TAIL;
                    end
                end
                S_TAIL:
                begin
                    hcnt_q <= hcnt_q + 4'h1;
                    if (hcnt_q == dg_pkg::TAIL_BYTES - 4'h1)
                    begin
                        state_q <= more_q ? S_IDLE : S_IDLE;
                        hcnt_q <= 4'h0;
                        if (more_q)
                        begin
                            state_q <= S_HEAD;
                            hcnt_q <= dg_pkg::POS_INDEX;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
            if (state_q == S_TAIL && more_q
                && hcnt_q == dg_pkg::TAIL_BYTES - 4'h1)
                cmd_q <= cmd_q;
        end
    end
    assign addressed = hit_q;
    assign busy = state_q != S_IDLE;

    // ------------------------------------------------------------
    // Memory offset walk
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            off_q <= 16'h0000;
        else if (in_valid && state_q == S_HEAD
            && hcnt_q == dg_pkg::POS_LEN0)
            off_q <= logical ? adr_q[15:0] : adr_q[31:16];
        else if (in_pay)
            off_q <= off_q + 16'h0001;
    end

    // ------------------------------------------------------------
    // Memory access, write only when addressed
    // ------------------------------------------------------------
    assign mb.addr = off_q;
    assign mb.rd = in_pay && hit_q && do_rd;
    assign mb.wr = in_pay && hit_q && do_wr;
    assign mb.wdata = in_data;
    local_mem u_mem (
        .clk(clk),
        .m(mb)
    );

    // ------------------------------------------------------------
    // Pipeline stage one: position increment on the fly
    // ------------------------------------------------------------
    logic inc_lo;
    logic inc_hi;
    logic [8:0] lo_sum;
    assign inc_lo = state_q == S_HEAD && hcnt_q == dg_pkg::POS_ADR0
        && (fam == dg_pkg::ADR_POS || fam == dg_pkg::ADR_ALL);
    assign inc_hi = state_q == S_HEAD && hcnt_q == dg_pkg::POS_ADR1
        && (fam == dg_pkg::ADR_POS || fam == dg_pkg::ADR_ALL);
    assign lo_sum = {1'b0, in_data} + {1'b0, dg_pkg::POS_STEP[7:0]};
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            d1_q <= 8'h00;
            v1_q <= 1'b0;
            s1_q <= 1'b0;
            pay1_q <= 1'b0;
            carry_q <= 1'b0;
        end
        else
        begin
            v1_q <= in_valid;
            s1_q <= in_valid && in_sof && state_q == S_IDLE;
            pay1_q <= mb.rd;
            d1_q <= in_data;
            if (in_valid && inc_lo)
            begin
                d1_q <= lo_sum[7:0];
                carry_q <= lo_sum[8];
            end
            else if (in_valid && inc_hi)
                d1_q <= in_data + {7'h00, carry_q};
        end
    end

    // ------------------------------------------------------------
    // Pipeline stage two: merge read data into payload
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            out_data_q <= 8'h00;
            out_valid_q <= 1'b0;
            out_sof_q <= 1'b0;
        end
        else
        begin
            out_valid_q <= v1_q;
            out_sof_q <= s1_q;
            if (!pay1_q)
                out_data_q <= d1_q;
            else if (do_or)
                out_data_q <= d1_q | mb.rdata;
            else
                out_data_q <= mb.rdata;
        end
    end
    assign out_data = out_data_q;
    assign out_valid = out_valid_q;
    assign out_sof = out_sof_q;
endmodule

// [hdl/dg_pkg.sv]
/*
 * Constants, opcodes and types for the datagram address decoder.
 * Assumes a byte stream that starts at the datagram command byte.
 */
package dg_pkg;
    // -------------------------------------------------------------
    // Command codes
    // -------------------------------------------------------------
    localparam logic [7:0] IDLE_CMD = 8'h00;
    localparam logic [7:0] POSITION_READ_CMD = 8'h01;
    localparam logic [7:0] POSITION_WRITE_CMD = 8'h02;
    localparam logic [7:0] POSITION_SWAP_CMD = 8'h03;
    localparam logic [7:0] NODE_READ_CMD = 8'h04;
    localparam logic [7:0] NODE_WRITE_CMD = 8'h05;
    localparam logic [7:0] NODE_SWAP_CMD = 8'h06;
    localparam logic [7:0] ALL_OR_READ_CMD = 8'h07;
    localparam logic [7:0] ALL_WRITE_CMD = 8'h08;
    localparam logic [7:0] ALL_OR_SWAP_CMD = 8'h09;
    localparam logic [7:0] LOGICAL_READ_CMD = 8'h0A;
    localparam logic [7:0] LOGICAL_WRITE_CMD = 8'h0B;
    localparam logic [7:0] LOGICAL_SWAP_CMD = 8'h0C;
    // -------------------------------------------------------------
    // Header layout, byte positions from the command byte
    // -------------------------------------------------------------
    localparam logic [3:0] POS_CMD = 4'h0;
    localparam logic [3:0] POS_INDEX = 4'h1;
    localparam logic [3:0] POS_ADR0 = 4'h2;
    localparam logic [3:0] POS_ADR1 = 4'h3;
    localparam logic [3:0] POS_ADR2 = 4'h4;
    localparam logic [3:0] POS_ADR3 = 4'h5;
    localparam logic [3:0] POS_LEN0 = 4'h6;
    localparam logic [3:0] POS_LEN1 = 4'h7;
    localparam logic [3:0] POS_IRQ1 = 4'h9;
    localparam logic [3:0] TAIL_BYTES = 4'h2;
    localparam int LEN_W = 11;
    localparam logic [2:0] LEN_HI_W = 3'h3;
    localparam int MORE_BIT = 7;
    localparam int MEM_AW = 16;
    localparam logic [15:0] POS_ZERO = 16'h0000;
    localparam logic [15:0] POS_STEP = 16'h0001;
    localparam logic [15:0] ALIAS_RESET = 16'h0000;
    localparam logic [15:0] STATION_RESET = 16'h0000;

    typedef enum logic [1:0] {ADR_NONE, ADR_POS, ADR_NODE, ADR_ALL} family_t;
endpackage

// [hdl/local_mem.sv]
/*
 * Local register and memory space reached by datagrams.
 * Assumes a depth fixed by parameter, address wraps by truncation.
 */
`timescale 1ns/10ps
module local_mem #(
    parameter int DEPTH_W = 10
) (
    // Clock
    input wire logic clk,
    // Access
    mem_if.slave m
);
    logic [7:0] mem_q [0:(1<<DEPTH_W)-1];
    logic [7:0] rdata_q;

    // ------------------------------------------------------------
    // Storage, read-before-write gives the swap its old data
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (m.wr)
            mem_q[m.addr[DEPTH_W-1:0]] <= m.wdata;
    end

    always_ff @(posedge clk)
    begin
        rdata_q <= mem_q[m.addr[DEPTH_W-1:0]];
    end

    assign m.rdata = rdata_q;
endmodule

// [hdl/mem_if.sv]
/*
 * Local memory access bundle between decoder and its memory.
 * Assumes single-cycle synchronous reads.
 */
`timescale 1ns/10ps
interface mem_if;
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport master (output addr, output rd, output wr, output wdata,
        input rdata);
    modport slave (input addr, input rd, input wr, input wdata,
        output rdata);
endinterface
